// [common/bpm_cfg.svh]
`ifndef BPM_CFG_SVH
`define BPM_CFG_SVH

// Register word indices on the bus; byte address is index times four.
`define BPM_IDX_BP_LAST   4'h7
`define BPM_IDX_STATUS    4'h8
`define BPM_IDX_CONTROL   4'h9

// Status fields.
`define BPM_ST_ACCESS     13
`define BPM_ST_STEP       14
`define BPM_ST_TASK       15
`define BPM_STATUS_RESET  32'h00000000

// Control fields.
`define BPM_CT_GD         13
`define BPM_CT_RW_LSB     16
`define BPM_CT_LEN_LSB    18
`define BPM_CT_STEP       4
`define BPM_CONTROL_RESET 32'h00000000

// Length codes.
`define BPM_LEN_1         2'b00
`define BPM_LEN_2         2'b01
`define BPM_LEN_8         2'b10
`define BPM_LEN_4         2'b11

// Exception vectors.
`define BPM_VEC_DEBUG     8'h01
`define BPM_VEC_BRK       8'h03

// Bus answers.
`define BPM_RESP_OKAY     2'b00
`define BPM_RESP_SLVERR   2'b10

`endif

// [common/bpm_pkg.sv]
package bpm_pkg;

    typedef enum logic [1:0] {
        MATCH_EXEC,
        MATCH_WRITE,
        MATCH_IO,
        MATCH_RW
    } match_type_type;

    typedef enum logic [1:0] {
        ACC_FETCH,
        ACC_READ,
        ACC_WRITE,
        ACC_IO
    } access_kind_type;

endpackage

// [common/range_cmp_if.sv]
`timescale 1ns/10ps
interface range_cmp_if;
    logic [63:0] base;
    logic [1:0]  len_code;
    logic [63:0] acc_addr;
    logic [3:0]  acc_size;
    logic        hit;

    modport requester (
        output base,
        output len_code,
        output acc_addr,
        output acc_size,
        input  hit
    );

    modport matcher (
        input  base,
        input  len_code,
        input  acc_addr,
        input  acc_size,
        output hit
    );
endinterface

// [dv/bpm_checker_assertions.sv]
`timescale 1ns/10ps
`include "bpm_cfg.svh"
module bpm_checker (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    // Core side
    input wire logic        long_mode,
    input wire logic        insn_done,
    input wire logic        step_trap,
    input wire logic        brk_insn,
    input wire logic        mov_valid,
    input wire logic        mov_write,
    input wire logic [2:0]  mov_index,
    input wire logic        mov_done,
    input wire logic [63:0] mov_rdata,
    input wire logic        mov_gp_fault,
    // Exception request
    input wire logic        exc_valid,
    input wire logic [7:0]  exc_vector,
    input wire logic        exc_fault,
    input wire logic        exc_trap
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_mov_answer: assert property (
        mov_valid |=> mov_done) else $error("register move unanswered");
    a_short_read: assert property (
        mov_done && !$past(mov_write) && !$past(long_mode)
        |-> mov_rdata[63:32] == 32'h0) else $error("upper half not zero");
    a_gp_long_only: assert property (
        mov_gp_fault |-> mov_done && $past(long_mode) && $past(mov_write)
        && $past(mov_index[2])) else $error("protection fault misplaced");
    a_fault_debug: assert property (
        exc_fault |-> exc_valid && exc_vector == `BPM_VEC_DEBUG)
        else $error("fault outside debug delivery");
    a_debug_cause: assert property (
        exc_valid && exc_vector == `BPM_VEC_DEBUG
        |-> $past(insn_done) && (exc_fault || exc_trap))
        else $error("debug delivery without cause");
    a_brk_vector: assert property (
        brk_insn |-> ##[1:2] (exc_valid && exc_vector == `BPM_VEC_BRK))
        else $error("breakpoint vector missing");
    a_step_trap: assert property (
        insn_done && step_trap |=> exc_valid && exc_trap)
        else $error("step trap not raised");
    a_idle_vector: assert property (
        !exc_valid |-> exc_vector == 8'h00) else $error("vector while idle");
    a_read_answer: assert property (
        arvalid && arready |=> rvalid) else $error("read not answered");

    c_both: cover property (exc_valid && exc_fault && exc_trap);
    c_gp: cover property (mov_gp_fault);
    c_brk: cover property (exc_valid && exc_vector == `BPM_VEC_BRK);
endmodule

bind breakpoint_match_unit bpm_checker chk_i (.*);

// [dv/breakpoint_match_unit_tb_top.sv]
`timescale 1ns/10ps
`include "bpm_cfg.svh"
module breakpoint_match_unit_tb_top;
    import bpm_pkg::*;

    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 1;
    logic arvalid = 0, rready = 1, awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr = 0, araddr = 0, exc_vector;
    logic [31:0] wdata = 0, rdata;
    logic [3:0]  wstrb = 4'hF, acc_size;
    logic [1:0]  bresp, rresp;
    logic long_mode, acc_valid, acc_insn_start, insn_done, step_trap;
    logic task_trap, task_switch, brk_insn, mov_valid, mov_write, mov_done;
    logic mov_gp_fault, exc_valid, exc_fault, exc_trap;
    logic [2:0]  mov_index;
    logic [63:0] acc_addr, mov_wdata, mov_rdata;
    access_kind_type acc_kind;
    int bad_count = 0;
    int checks = 0;
    logic [31:0] d;

    breakpoint_match_unit uut (.*);

    core_model core (.*);

    always #20 aclk = ~aclk;

    task final_report();
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input string s, input logic [63:0] e, input logic [63:0] g);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask

    // Ready is registered, so its value at the falling edge is the one
    // that the next rising edge samples.
    task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        tb = 1'b0;
        awaddr <= a;
        wdata <= v;
        {awvalid, wvalid} <= 2'h3;
        while (!tb)
        begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        chk("bresp", {tb, er}, {1'b1, r});
    endtask

    task rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
        logic ta, tr;
        tr = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!tr)
        begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            d = rdata;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        chk("rdata", {tr, er, ev}, {1'b1, rresp, d});
    endtask

    // One instruction: an access, its boundary, then the status flags.
    task run(input access_kind_type k, input logic [63:0] a,
             input logic [3:0] n, input logic s, input logic [3:0] m,
             input logic f);
        core.access(k, a, n, s);
        core.boundary(1'b0, 1'b0);
        @(negedge aclk);
        chk("exception", {m != 4'h0, f, m != 4'h0 && !f},
            {exc_valid, exc_fault, exc_trap});
        @(posedge aclk);
        if (m != 4'h0)
            rd(8'h20, {28'h0, m}, `BPM_RESP_OKAY);
    endtask

    task mv(input logic w, input logic [2:0] i, input logic [63:0] v,
            input logic [63:0] er, input logic eg);
        core.mov(w, i, v);
        @(negedge aclk);
        chk("move", {mov_done, mov_gp_fault}, {1'b1, eg});
        if (!w)
            chk("mov_rdata", er, mov_rdata);
        @(posedge aclk);
    endtask

    initial
    begin
        #2000000;
        bad_count++;
        final_report();
    end

    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(8'h20, `BPM_STATUS_RESET, `BPM_RESP_OKAY);
        rd(8'h24, `BPM_CONTROL_RESET, `BPM_RESP_OKAY);
        rd(8'h28, 32'h0, `BPM_RESP_SLVERR);
        wr(8'h28, 32'h1, `BPM_RESP_SLVERR);
        // aligned ranges of 1, 2, 4 bytes
        wr(8'h00, 32'h000A_0001, `BPM_RESP_OKAY);
        wr(8'h08, 32'h000A_0002, `BPM_RESP_OKAY);
        wr(8'h10, 32'h000B_0002, `BPM_RESP_OKAY);
        wr(8'h18, 32'h000C_0000, `BPM_RESP_OKAY);
        wr(8'h24, 32'hD713_00AA, `BPM_RESP_OKAY);
        run(ACC_READ, 64'hA0001, 4'h1, 1'b0, 4'h1, 1'b0);
        run(ACC_READ, 64'hA0001, 4'h2, 1'b0, 4'h1, 1'b0);
        run(ACC_WRITE, 64'hA0001, 4'h2, 1'b0, 4'h3, 1'b0);
        run(ACC_WRITE, 64'hA0002, 4'h1, 1'b0, 4'h2, 1'b0);
        run(ACC_WRITE, 64'hA0002, 4'h2, 1'b0, 4'h2, 1'b0);
        run(ACC_READ, 64'hB0001, 4'h4, 1'b0, 4'h4, 1'b0);
        run(ACC_READ, 64'hB0002, 4'h1, 1'b0, 4'h4, 1'b0);
        run(ACC_READ, 64'hB0002, 4'h2, 1'b0, 4'h4, 1'b0);
        run(ACC_WRITE, 64'hC0000, 4'h4, 1'b0, 4'h8, 1'b0);
        run(ACC_WRITE, 64'hC0001, 4'h2, 1'b0, 4'h8, 1'b0);
        run(ACC_WRITE, 64'hC0003, 4'h1, 1'b0, 4'h8, 1'b0);
        run(ACC_READ, 64'hA0000, 4'h1, 1'b0, 4'h0, 1'b0);
        run(ACC_READ, 64'hA0002, 4'h1, 1'b0, 4'h0, 1'b0);
        run(ACC_READ, 64'hA0003, 4'h4, 1'b0, 4'h0, 1'b0);
        run(ACC_READ, 64'hB0000, 4'h2, 1'b0, 4'h0, 1'b0);
        run(ACC_READ, 64'hC0000, 4'h2, 1'b0, 4'h0, 1'b0);
        run(ACC_WRITE, 64'hC0004, 4'h4, 1'b0, 4'h0, 1'b0);
        // execution breakpoint uses the one-byte code
        wr(8'h00, 32'h0000_1234, `BPM_RESP_OKAY);
        wr(8'h08, 32'h0000_4000, `BPM_RESP_OKAY);
        wr(8'h10, 32'h0000_D000, `BPM_RESP_OKAY);
        wr(8'h18, 32'h0000_E000, `BPM_RESP_OKAY);
        wr(8'h24, 32'h3902_002A, `BPM_RESP_OKAY);
        run(ACC_IO, 64'hFFFF_0000_0000_1234, 4'h1, 1'b0, 4'h1, 1'b0);
        run(ACC_READ, 64'h1234, 4'h1, 1'b0, 4'h0, 1'b0);
        run(ACC_WRITE, 64'hD007, 4'h1, 1'b0, 4'h4, 1'b0);
        run(ACC_WRITE, 64'hCFFF, 4'h2, 1'b0, 4'h4, 1'b0);
        run(ACC_WRITE, 64'hD008, 4'h1, 1'b0, 4'h0, 1'b0);
        run(ACC_FETCH, 64'h4000, 4'h1, 1'b1, 4'h2, 1'b1);
        run(ACC_FETCH, 64'h4000, 4'h1, 1'b0, 4'h0, 1'b0);
        run(ACC_READ, 64'h4000, 4'h1, 1'b0, 4'h0, 1'b0);
        run(ACC_READ, 64'hE000, 4'h1, 1'b0, 4'h0, 1'b0);
        mv(1'b1, 3'h0, 64'hDEAD_BEEF_1234_5678, 64'h0, 1'b0);
        mv(1'b0, 3'h0, 64'h0, 64'h1234_5678, 1'b0);
        core.mode(1'b1);
        mv(1'b1, 3'h3, 64'hFFFF_8000_0000_0040, 64'h0, 1'b0);
        mv(1'b0, 3'h3, 64'h0, 64'hFFFF_8000_0000_0040, 1'b0);
        mv(1'b1, 3'h7, 64'h1_0000_0000, 64'h0, 1'b1);
        mv(1'b0, 3'h5, 64'h0, 64'h3902_002A, 1'b0);
        core.mode(1'b0);
        wr(8'h24, 32'h0000_2000, `BPM_RESP_OKAY);
        mv(1'b0, 3'h0, 64'h0, 64'h0, 1'b0);
        core.boundary(1'b1, 1'b1);
        @(negedge aclk);
        chk("exc both", 3'h7, {exc_valid, exc_fault, exc_trap});
        @(posedge aclk);
        rd(8'h20, 32'h0000_E000, `BPM_RESP_OKAY);
        rd(8'h24, 32'h0, `BPM_RESP_OKAY);
        core.ctl(1'b0, 1'b1);
        @(negedge aclk);
        chk("brk", {1'b1, `BPM_VEC_BRK}, {exc_valid, exc_vector});
        @(posedge aclk);
        wr(8'h24, 32'h0000_00FF, `BPM_RESP_OKAY);
        core.ctl(1'b1, 1'b0);
        rd(8'h24, 32'h0000_00AA, `BPM_RESP_OKAY);
        final_report();
    end
endmodule

// [dv/core_model.sv]
`timescale 1ns/10ps
module core_model (
    // Clock
    input wire logic                 aclk,
    // Core stream
    output logic                     long_mode,
    output logic                     acc_valid,
    output bpm_pkg::access_kind_type acc_kind,
    output logic [63:0]              acc_addr,
    output logic [3:0]               acc_size,
    output logic                     acc_insn_start,
    output logic                     insn_done,
    output logic                     step_trap,
    output logic                     task_trap,
    output logic                     task_switch,
    output logic                     brk_insn,
    output logic                     mov_valid,
    output logic                     mov_write,
    output logic [2:0]               mov_index,
    output logic [63:0]              mov_wdata
);
    import bpm_pkg::*;

    // Every request but a mode change lasts exactly one cycle, as the pipeline issues it; long_mode holds.
    initial
    begin
        {long_mode, acc_valid, acc_insn_start, insn_done} = 4'h0;
        {step_trap, task_trap, task_switch, brk_insn} = 4'h0;
        {mov_valid, mov_write, mov_index} = 5'h00;
        acc_kind = ACC_FETCH;
        acc_addr = 64'h0;
        acc_size = 4'h0;
        mov_wdata = 64'h0;
    end

    task mode(input logic m);
        long_mode <= m;
        @(posedge aclk);
    endtask

    task access(input access_kind_type k, input logic [63:0] a,
                input logic [3:0] n, input logic s);
        acc_valid <= 1'b1;
        acc_kind <= k;
        acc_addr <= a;
        acc_size <= n;
        acc_insn_start <= s;
        @(posedge aclk);
        acc_valid <= 1'b0;
    endtask

    task boundary(input logic s, input logic t);
        insn_done <= 1'b1;
        step_trap <= s;
        task_trap <= t;
        @(posedge aclk);
        {insn_done, step_trap, task_trap} <= 3'h0;
    endtask

    task mov(input logic w, input logic [2:0] i, input logic [63:0] d);
        mov_valid <= 1'b1;
        mov_write <= w;
        mov_index <= i;
        mov_wdata <= d;
        @(posedge aclk);
        mov_valid <= 1'b0;
    endtask

    task ctl(input logic sw, input logic brk);
        task_switch <= sw;
        brk_insn <= brk;
        @(posedge aclk);
        {task_switch, brk_insn} <= 2'h0;
    endtask
endmodule

// [logic/breakpoint_match_unit.sv]
// Contract
// - Each address register plus length defines a 1/2/4/8-byte range.
// - Length code masks low address bits, forcing range alignment.
// - I/O port addresses are zero-extended before comparison.
// - Data hit when any byte of an access lies in range.
// - Execution breakpoint hits only on first byte of an instruction.
// - Registers are 64 bits; outside 64-bit mode upper half zeroed.
// - In 64-bit mode register moves use all 64 bits.
// - Setting upper status/control bits in 64-bit mode raises GP(0).
// - Address registers fully writable; no limit check on writes.
// - Eight-byte data ranges work in every mode.
// - Debug exceptions use vector 1, breakpoint instruction vector 3.
// - Execution and protection hits are faults; others are traps.
// - One delivery may carry faults and traps; flags show all.
// - Hit flags set by type: exec, write, I/O, read/write.
// - Register move under protection raises fault with access flag.
// - Length codes: 00 one, 01 two, 11 four, 10 eight bytes.
// - Comparison uses linear addresses before translation.
// - Exception only if local or global enable; task switch clears local.
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "bpm_cfg.svh"
module breakpoint_match_unit #(
    parameter bit EIGHT_BYTE_OK = 1'b1
) (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite register port
    input  wire logic [7:0]            awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [7:0]            araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    // Core accesses and boundaries
    input  wire logic                  long_mode,
    input  wire logic                  acc_valid,
    input  wire bpm_pkg::access_kind_type acc_kind,
    input  wire logic [63:0]           acc_addr,
    input  wire logic [3:0]            acc_size,
    input  wire logic                  acc_insn_start,
    input  wire logic                  insn_done,
    input  wire logic                  step_trap,
    input  wire logic                  task_trap,
    input  wire logic                  task_switch,
    input  wire logic                  brk_insn,
    // Core register moves
    input  wire logic                  mov_valid,
    input  wire logic                  mov_write,
    input  wire logic [2:0]            mov_index,
    input  wire logic [63:0]           mov_wdata,
    output logic                       mov_done,
    output logic [63:0]                mov_rdata,
    output logic                       mov_gp_fault,
    // Exception request
    output logic                       exc_valid,
    output logic [7:0]                 exc_vector,
    output logic                       exc_fault,
    output logic                       exc_trap
);
    import bpm_pkg::*;

    logic [63:0] bp_addr_reg [4];
    logic [31:0] status_reg;
    logic [31:0] control_reg;
    logic [3:0]  pend_fault_reg;
    logic [3:0]  pend_trap_reg;
    logic        pend_gd_reg;
    logic        brk_pend_reg;
    logic        aw_have_reg;
    logic        w_have_reg;
    logic [3:0]  aw_idx_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;

    logic [3:0]  cond_fetch;
    logic [3:0]  cond_data;
    logic [3:0]  enabled;
    logic [63:0] cmp_addr;
    logic        gd_block;
    logic        mov_ok;
    logic        mov_gp;
    logic [63:0] mov_data;
    logic        axi_wr;
    logic [3:0]  fault_next;
    logic [3:0]  trap_next;
    logic        fault_now;
    logic        trap_now;
    logic        deliver;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                res[b*8 +: 8] = data[b*8 +: 8];
        end
        return res;
    endfunction

    assign cmp_addr = (acc_kind == ACC_IO) ? {48'h0, acc_addr[15:0]}
                                           : acc_addr;

    for (genvar i = 0; i < 4; i++)
    begin : g_bp
        range_cmp_if cmp ();
        match_type_type mtype;
        logic           is_exec;

        assign cmp.base     = bp_addr_reg[i];
        assign cmp.len_code = control_reg[`BPM_CT_LEN_LSB
                                          + i*`BPM_CT_STEP +: 2];
        assign cmp.acc_addr = cmp_addr;
        assign cmp.acc_size = acc_size;
        assign mtype = match_type_type'(control_reg[`BPM_CT_RW_LSB
                                        + i*`BPM_CT_STEP +: 2]);
        assign is_exec = acc_valid && acc_kind == ACC_FETCH
                      && acc_insn_start && acc_addr == bp_addr_reg[i];
        assign cond_fetch[i] = mtype == MATCH_EXEC && is_exec;
        assign cond_data[i] = acc_valid && cmp.hit
            && ((mtype == MATCH_WRITE && acc_kind == ACC_WRITE)
             || (mtype == MATCH_IO && acc_kind == ACC_IO)
             || (mtype == MATCH_RW && (acc_kind == ACC_READ
                                    || acc_kind == ACC_WRITE)));
        assign enabled[i] = control_reg[2*i] | control_reg[2*i + 1];

        range_compare #(
            .EIGHT_BYTE_OK (EIGHT_BYTE_OK)
        ) u_cmp (
            .cmp (cmp.matcher)
        );
    end

    assign gd_block = mov_valid && control_reg[`BPM_CT_GD];
    assign mov_gp = mov_valid && mov_write && !gd_block && long_mode
                 && mov_index[2] && mov_wdata[63:32] != 32'h0;
    assign mov_ok = mov_valid && mov_write && !gd_block && !mov_gp;
    assign mov_data = long_mode ? mov_wdata : {32'h0, mov_wdata[31:0]};
    assign axi_wr = aw_have_reg && w_have_reg && !bvalid;

    // Accesses in the boundary cycle belong to the next instruction.
    assign fault_next = (insn_done ? 4'h0 : pend_fault_reg) | cond_fetch;
    assign trap_next  = (insn_done ? 4'h0 : pend_trap_reg) | cond_data;
    assign fault_now = |(pend_fault_reg & enabled) | pend_gd_reg;
    assign trap_now  = |(pend_trap_reg & enabled) | step_trap | task_trap;
    assign deliver = insn_done && (fault_now || trap_now);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pend_fault_reg <= 4'h0;
            pend_trap_reg  <= 4'h0;
            pend_gd_reg    <= 1'b0;
        end
        else
        begin
            pend_fault_reg <= fault_next;
            pend_trap_reg  <= trap_next;
            pend_gd_reg    <= (pend_gd_reg && !insn_done) || gd_block;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < 4; i++)
                bp_addr_reg[i] <= 64'h0;
        end
        else
        begin
            if (mov_ok && !mov_index[2])
                bp_addr_reg[mov_index[1:0]] <= mov_data;
            if (axi_wr && aw_idx_reg <= `BPM_IDX_BP_LAST)
            begin
                if (aw_idx_reg[0])
                    bp_addr_reg[aw_idx_reg[2:1]][63:32] <= merge(
                        bp_addr_reg[aw_idx_reg[2:1]][63:32],
                        wdata_reg, wstrb_reg);
                else
                    bp_addr_reg[aw_idx_reg[2:1]][31:0] <= merge(
                        bp_addr_reg[aw_idx_reg[2:1]][31:0],
                        wdata_reg, wstrb_reg);
            end
        end
    end

    // Exception flags are applied after any write so a set is never lost.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            status_reg <= `BPM_STATUS_RESET;
        else
        begin
            logic [31:0] s;
            s = status_reg;
            if (mov_ok && mov_index[2] && !mov_index[0])
                s = mov_data[31:0];
            if (axi_wr && aw_idx_reg == `BPM_IDX_STATUS)
                s = merge(s, wdata_reg, wstrb_reg);
            if (deliver)
            begin
                s[3:0] = pend_fault_reg | pend_trap_reg;
                s[`BPM_ST_ACCESS] = s[`BPM_ST_ACCESS] | pend_gd_reg;
                s[`BPM_ST_STEP]   = s[`BPM_ST_STEP] | step_trap;
                s[`BPM_ST_TASK]   = s[`BPM_ST_TASK] | task_trap;
            end
            status_reg <= s;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            control_reg <= `BPM_CONTROL_RESET;
        else
        begin
            logic [31:0] c;
            c = control_reg;
            if (mov_ok && mov_index[2] && mov_index[0])
                c = mov_data[31:0];
            if (axi_wr && aw_idx_reg == `BPM_IDX_CONTROL)
                c = merge(c, wdata_reg, wstrb_reg);
            // The handler must be free to reach the registers.
            if (deliver)
                c[`BPM_CT_GD] = 1'b0;
            if (task_switch)
                for (int i = 0; i < 4; i++)
                    c[2*i] = 1'b0;
            control_reg <= c;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mov_done     <= 1'b0;
            mov_rdata    <= 64'h0;
            mov_gp_fault <= 1'b0;
        end
        else
        begin
            mov_done     <= mov_valid;
            mov_gp_fault <= mov_gp;
            if (mov_valid && !mov_write && !gd_block)
            begin
                logic [63:0] r;
                if (!mov_index[2])
                    r = bp_addr_reg[mov_index[1:0]];
                else if (mov_index[0])
                    r = {32'h0, control_reg};
                else
                    r = {32'h0, status_reg};
                mov_rdata <= long_mode ? r : {32'h0, r[31:0]};
            end
            else
                mov_rdata <= 64'h0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            exc_valid    <= 1'b0;
            exc_vector   <= 8'h00;
            exc_fault    <= 1'b0;
            exc_trap     <= 1'b0;
            brk_pend_reg <= 1'b0;
        end
        else
        begin
            exc_valid  <= deliver || brk_insn || brk_pend_reg;
            exc_fault  <= deliver && fault_now;
            exc_trap   <= deliver && trap_now;
            // Debug wins a collision; the breakpoint waits for the next cycle without a debug delivery.
            if (deliver)
            begin
                exc_vector   <= `BPM_VEC_DEBUG;
                brk_pend_reg <= brk_insn || brk_pend_reg;
            end
            else if (brk_insn || brk_pend_reg)
            begin
                exc_vector   <= `BPM_VEC_BRK;
                brk_pend_reg <= 1'b0;
            end
            else
                exc_vector <= 8'h00;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready     <= 1'b1;
            wready      <= 1'b1;
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            aw_idx_reg  <= 4'h0;
            wdata_reg   <= 32'h0;
            wstrb_reg   <= 4'h0;
            bvalid      <= 1'b0;
            bresp       <= `BPM_RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_have_reg <= 1'b1;
                awready     <= 1'b0;
                aw_idx_reg  <= awaddr[5:2];
            end
            if (wvalid && wready)
            begin
                w_have_reg <= 1'b1;
                wready     <= 1'b0;
                wdata_reg  <= wdata;
                wstrb_reg  <= wstrb;
            end
            if (axi_wr)
            begin
                bvalid      <= 1'b1;
                aw_have_reg <= 1'b0;
                w_have_reg  <= 1'b0;
                bresp <= (awaddr_ok(aw_idx_reg)) ? `BPM_RESP_OKAY
                                                 : `BPM_RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    function automatic logic awaddr_ok(input logic [3:0] idx);
        return idx <= `BPM_IDX_CONTROL;
    endfunction

    // Unmapped or high addresses read zero with an error answer.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= `BPM_RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= (araddr[7:6] == 2'b00 && awaddr_ok(araddr[5:2]))
                       ? `BPM_RESP_OKAY : `BPM_RESP_SLVERR;
            if (araddr[7:6] != 2'b00)
                rdata <= 32'h0;
            else if (araddr[5:2] <= `BPM_IDX_BP_LAST)
                rdata <= araddr[2] ? bp_addr_reg[araddr[4:3]][63:32]
                                   : bp_addr_reg[araddr[4:3]][31:0];
            else if (araddr[5:2] == `BPM_IDX_STATUS)
                rdata <= status_reg;
            else if (araddr[5:2] == `BPM_IDX_CONTROL)
                rdata <= control_reg;
            else
                rdata <= 32'h0;
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end
endmodule

// [logic/range_compare.sv]
`timescale 1ns/10ps
`include "bpm_cfg.svh"
module range_compare #(
    parameter bit EIGHT_BYTE_OK = 1'b1
) (
    range_cmp_if.matcher cmp
);
    logic [63:0] span;
    logic [63:0] lo;
    logic [63:0] hi;
    logic [64:0] acc_end;

    always_comb
    begin
        case (cmp.len_code)
            `BPM_LEN_2: span = 64'h1;
            `BPM_LEN_4: span = 64'h3;
            `BPM_LEN_8: span = EIGHT_BYTE_OK ? 64'h7 : 64'h0;
            default:    span = 64'h0;
        endcase
    end

    assign lo = cmp.base & ~span;
    assign hi = lo | span;
    assign acc_end = {1'b0, cmp.acc_addr} + {61'h0, cmp.acc_size} - 65'h1;

    assign cmp.hit = (cmp.acc_size != 4'h0) && (cmp.acc_addr <= hi)
                   && (acc_end >= {1'b0, lo});
endmodule
